// ===== core/scg_map.svh
// register map, field positions, reset values and rate table constants
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH

`define SCG_GAIN_W 24
`define SCG_FRAC_W 22
`define SCG_CMD_W 8
`define SCG_CMD_RD_BIT 7
`define SCG_BYTE_W 8

`define SCG_REG_GAIN 2'h0
`define SCG_REG_CONTROL_REG_THREE 2'h1
`define SCG_REG_CONV 2'h2
`define SCG_REG_NONE 2'h3

`define SCG_BYPASS_BIT 0
`define SCG_RATE_LSB 0
`define SCG_LINE_FREQ_SELECT_BIT 3
`define SCG_CALREQ_BIT 4
`define SCG_CALACT_BIT 5

`define SCG_GAIN_RST 24'h000000
`define SCG_UNITY_GAIN 24'h400000
`define SCG_MAX_GAIN 24'h7FFFFF
`define SCG_PIN_IDLE 3'h2

// rates in milli-samples per second
`define SCG_S60_R0 19'd1000
`define SCG_S60_R1 19'd2500
`define SCG_S60_R2 19'd5000
`define SCG_S60_R3 19'd10000
`define SCG_S60_R4 19'd15000
`define SCG_S60_R5 19'd30000
`define SCG_S60_R6 19'd60000
`define SCG_S60_R7 19'd120000
`define SCG_S50_R0 19'd833
`define SCG_S50_R1 19'd2080
`define SCG_S50_R2 19'd4170
`define SCG_S50_R3 19'd8330
`define SCG_S50_R4 19'd12500
`define SCG_S50_R5 19'd25000
`define SCG_S50_R6 19'd50000
`define SCG_S50_R7 19'd100000
`define SCG_C60_R4 19'd60000
`define SCG_C60_R5 19'd120000
`define SCG_C60_R6 19'd240000
`define SCG_C60_R7 19'd480000
`define SCG_C50_R4 19'd50000
`define SCG_C50_R5 19'd100000
`define SCG_C50_R6 19'd200000
`define SCG_C50_R7 19'd400000

`endif

// ===== core/scg_pkg.sv
// types shared by the gain stage and its serial register port
`include "scg_map.svh"
package scg_pkg;
    typedef enum logic [1:0] {
        SCG_SEL_GAIN = `SCG_REG_GAIN,
        SCG_SEL_CONTROL_REG_THREE = `SCG_REG_CONTROL_REG_THREE,
        SCG_SEL_CONV = `SCG_REG_CONV,
        SCG_SEL_NONE = `SCG_REG_NONE
    } scg_sel_e;
    typedef enum logic [1:0] {
        SCG_ST_IDLE = 2'b00,
        SCG_ST_CMD = 2'b01,
        SCG_ST_DATA = 2'b10,
        SCG_ST_SKIP = 2'b11
    } scg_frame_e;
    typedef logic [18:0] scg_rate_t;
endpackage

// ===== core/scg_gain_mul.sv
// signed fractional gain multiplier with rounding and saturation
`timescale 1ns/100ps
module scg_gain_mul #(
    parameter int W = 24,
    parameter int FRAC = 22
) (
    input wire logic [W-1:0] data_i, // offset-corrected sample
    input wire logic [W-1:0] gain_i, // two's complement gain
    output logic [W-1:0] data_o // scaled, saturated sample
);
    logic signed [2*W-1:0] prod;
    logic signed [2*W-1:0] rnd;
    logic signed [2*W-1:0] shf;

    if (FRAC >= W || FRAC < 1) begin : g_chk
        $error("scg_gain_mul: FRAC must be below W");
    end

    // round to nearest keeps the residual well inside two LSB
    always_comb begin
        prod = $signed(data_i) * $signed(gain_i);
        rnd = prod + $signed({{(2*W-FRAC){1'b0}}, 1'b1, {(FRAC-1){1'b0}}});
        shf = rnd >>> FRAC;
        if (!(&shf[2*W-1:W-1]) && (|shf[2*W-1:W-1])) begin
            data_o = shf[2*W-1] ? {1'b1, {(W-1){1'b0}}}
                                : {1'b0, {(W-1){1'b1}}};
        end else begin
            data_o = shf[W-1:0];
        end
    end
endmodule

// ===== core/scg_top.sv
// self-calibration gain stage, rate select and serial register port
`timescale 1ns/100ps
`include "scg_map.svh"
module scg_top
    import scg_pkg::*;
#(
    parameter int GAIN_W = `SCG_GAIN_W,
    parameter int FRAC_W = `SCG_FRAC_W
) (
    input wire logic clk_i, // 20 MHz core clock
    input wire logic rstn_i, // async reset, active low
    input wire logic sclk_i, // serial clock pin
    input wire logic cs_n_i, // serial select pin, active low
    input wire logic sdi_i, // serial data in pin
    output logic sdo_o, // serial data out pin
    output logic sdo_oen_o, // sdo enable, low while driving
    input wire logic cal_active_i, // calibration in progress
    input wire logic cal_done_i, // self-cal finished, one cycle
    input wire logic [GAIN_W-1:0] cal_gain_i, // calibrated gain
    input wire logic offs_valid_i, // offset-corrected sample strobe
    input wire logic [GAIN_W-1:0] offs_data_i, // offset-corrected sample
    output logic result_valid_o, // scaled sample strobe
    output logic [GAIN_W-1:0] result_o, // sample to system correction
    output logic self_cal_req_o, // self-cal start, one cycle
    output logic [2:0] rate_code_o, // selected rate code
    output logic line_freq_select_o, // 0: 60 Hz, 1: 50 Hz
    output scg_rate_t single_rate_o, // single-cycle rate, mSps
    output scg_rate_t cont_rate_o, // continuous rate, mSps
    output logic cont_avail_o // continuous rate exists
);
    if (GAIN_W != `SCG_GAIN_W || FRAC_W != `SCG_FRAC_W) begin : g_chk
        $error("scg_top: serial framing serves a 24-bit gain only");
    end

    logic [GAIN_W-1:0] self_cal_gain_value;
    logic self_gain_bypass;
    logic [2:0] rate_code;
    logic line_freq_select;
    logic [GAIN_W-1:0] scaled;

    // pin synchroniser: a change counts once stages two and three agree
    logic [2:0] pin_raw;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pin_lvl;
    logic sclk_d;
    assign pin_raw = {sclk_i, cs_n_i, sdi_i};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        localparam logic IDLE_V = 1'(`SCG_PIN_IDLE >> i);
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                sync1[i] <= IDLE_V;
                sync2[i] <= IDLE_V;
                sync3[i] <= IDLE_V;
                pin_lvl[i] <= IDLE_V;
            end else begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i]) begin
                    pin_lvl[i] <= sync3[i];
                end
            end
        end
    end

    logic sclk_lvl;
    logic cs_high;
    logic sdi_lvl;
    logic sclk_rise;
    assign sclk_lvl = pin_lvl[2];
    assign cs_high = pin_lvl[1];
    assign sdi_lvl = pin_lvl[0];
    assign sclk_rise = sclk_lvl && !sclk_d;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_lvl;
        end
    end

    function automatic scg_sel_e sel_decode(input logic [1:0] a);
        case (a)
            `SCG_REG_GAIN: sel_decode = SCG_SEL_GAIN;
            `SCG_REG_CONTROL_REG_THREE: sel_decode = SCG_SEL_CONTROL_REG_THREE;
            `SCG_REG_CONV: sel_decode = SCG_SEL_CONV;
            default: sel_decode = SCG_SEL_NONE;
        endcase
    endfunction

    // last data bit index of a register's field
    function automatic logic [4:0] last_bit(input scg_sel_e s);
        case (s)
            SCG_SEL_GAIN: last_bit = 5'(`SCG_GAIN_W - 1);
            default: last_bit = 5'(`SCG_BYTE_W - 1);
        endcase
    endfunction

    scg_frame_e state;
    logic [4:0] bit_cnt;
    logic [`SCG_CMD_W-1:0] cmd_sh;
    logic [GAIN_W-1:0] rx_sh;
    logic [GAIN_W-1:0] tx_sh;
    logic rd_flag;
    scg_sel_e sel;
    logic [`SCG_CMD_W-1:0] next_cmd;
    logic [GAIN_W-1:0] next_rx;
    logic cmd_done;
    logic wr_fire;
    logic [7:0] conv_rd;

    assign next_cmd = {cmd_sh[`SCG_CMD_W-2:0], sdi_lvl};
    assign next_rx = {rx_sh[GAIN_W-2:0], sdi_lvl};
    assign cmd_done = state == SCG_ST_CMD && sclk_rise
                      && bit_cnt == 5'(`SCG_CMD_W - 1);
    assign wr_fire = state == SCG_ST_DATA && sclk_rise && !rd_flag
                     && bit_cnt == last_bit(sel);
    assign conv_rd = 8'({cal_active_i, 1'b0, line_freq_select, rate_code});

    // frame sequencing; a raised select aborts whatever was in flight
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= SCG_ST_IDLE;
            bit_cnt <= 5'h00;
            cmd_sh <= 8'h00;
            rx_sh <= `SCG_GAIN_RST;
            rd_flag <= 1'b0;
            sel <= SCG_SEL_NONE;
        end else if (cs_high) begin
            state <= SCG_ST_IDLE;
            bit_cnt <= 5'h00;
        end else begin
            case (state)
                SCG_ST_IDLE: begin
                    state <= SCG_ST_CMD;
                    bit_cnt <= 5'h00;
                end
                SCG_ST_CMD: begin
                    if (sclk_rise) begin
                        cmd_sh <= next_cmd;
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                    if (cmd_done) begin
                        bit_cnt <= 5'h00;
                        rd_flag <= next_cmd[`SCG_CMD_RD_BIT];
                        sel <= sel_decode(next_cmd[1:0]);
                        state <= sel_decode(next_cmd[1:0]) == SCG_SEL_NONE
                                 ? SCG_ST_SKIP : SCG_ST_DATA;
                    end
                end
                SCG_ST_DATA: begin
                    if (sclk_rise) begin
                        rx_sh <= next_rx;
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == last_bit(sel)) begin
                            state <= SCG_ST_SKIP;
                        end
                    end
                end
                SCG_ST_SKIP: state <= SCG_ST_SKIP;
                default: state <= SCG_ST_IDLE;
            endcase
        end
    end

    // read data is left aligned so every register leaves msb first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_sh <= `SCG_GAIN_RST;
            sdo_oen_o <= 1'b1;
        end else begin
            sdo_oen_o <= cs_high;
            if (cmd_done && next_cmd[`SCG_CMD_RD_BIT]) begin
                case (sel_decode(next_cmd[1:0]))
                    SCG_SEL_GAIN: tx_sh <= self_cal_gain_value;
                    SCG_SEL_CONTROL_REG_THREE: tx_sh <= {7'h00, self_gain_bypass, 16'h0000};
                    SCG_SEL_CONV: tx_sh <= {conv_rd, 16'h0000};
                    default: tx_sh <= `SCG_GAIN_RST;
                endcase
            end else if (state == SCG_ST_DATA && rd_flag && sclk_rise) begin
                tx_sh <= {tx_sh[GAIN_W-2:0], 1'b0};
            end
        end
    end
    assign sdo_o = tx_sh[GAIN_W-1];

    // a finished self-cal beats a host write in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            self_cal_gain_value <= `SCG_GAIN_RST;
        end else if (cal_done_i) begin
            self_cal_gain_value <= cal_gain_i;
        end else if (wr_fire && sel == SCG_SEL_GAIN && !cal_active_i) begin
            self_cal_gain_value <= next_rx;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            self_gain_bypass <= 1'b0;
        end else if (wr_fire && sel == SCG_SEL_CONTROL_REG_THREE) begin
            self_gain_bypass <= next_rx[`SCG_BYPASS_BIT];
        end
    end

    // the request bit is write-only; it cannot restart a running cal
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rate_code <= 3'h0;
            line_freq_select <= 1'b0;
            self_cal_req_o <= 1'b0;
        end else begin
            self_cal_req_o <= wr_fire && sel == SCG_SEL_CONV && !cal_active_i
                              && next_rx[`SCG_CALREQ_BIT];
            if (wr_fire && sel == SCG_SEL_CONV) begin
                rate_code <= next_rx[`SCG_RATE_LSB +: 3];
                line_freq_select <= next_rx[`SCG_LINE_FREQ_SELECT_BIT];
            end
        end
    end

    scg_gain_mul #(
        .W(GAIN_W),
        .FRAC(FRAC_W)
    ) u_mul (
        .data_i(offs_data_i),
        .gain_i(self_cal_gain_value),
        .data_o(scaled)
    );

    // one register stage between offset and system correction
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_valid_o <= 1'b0;
            result_o <= `SCG_GAIN_RST;
        end else begin
            result_valid_o <= offs_valid_i;
            if (offs_valid_i) begin
                result_o <= self_gain_bypass ? offs_data_i : scaled;
            end
        end
    end

    function automatic scg_rate_t rate_lookup(input logic cont,
                                              input logic lf,
                                              input logic [2:0] rc);
        case ({cont, lf, rc})
            5'h00: rate_lookup = `SCG_S60_R0;
            5'h01: rate_lookup = `SCG_S60_R1;
            5'h02: rate_lookup = `SCG_S60_R2;
            5'h03: rate_lookup = `SCG_S60_R3;
            5'h04: rate_lookup = `SCG_S60_R4;
            5'h05: rate_lookup = `SCG_S60_R5;
            5'h06: rate_lookup = `SCG_S60_R6;
            5'h07: rate_lookup = `SCG_S60_R7;
            5'h08: rate_lookup = `SCG_S50_R0;
            5'h09: rate_lookup = `SCG_S50_R1;
            5'h0A: rate_lookup = `SCG_S50_R2;
            5'h0B: rate_lookup = `SCG_S50_R3;
            5'h0C: rate_lookup = `SCG_S50_R4;
            5'h0D: rate_lookup = `SCG_S50_R5;
            5'h0E: rate_lookup = `SCG_S50_R6;
            5'h0F: rate_lookup = `SCG_S50_R7;
            5'h14: rate_lookup = `SCG_C60_R4;
            5'h15: rate_lookup = `SCG_C60_R5;
            5'h16: rate_lookup = `SCG_C60_R6;
            5'h17: rate_lookup = `SCG_C60_R7;
            5'h1C: rate_lookup = `SCG_C50_R4;
            5'h1D: rate_lookup = `SCG_C50_R5;
            5'h1E: rate_lookup = `SCG_C50_R6;
            5'h1F: rate_lookup = `SCG_C50_R7;
            default: rate_lookup = 19'd0;
        endcase
    endfunction

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rate_code_o <= 3'h0;
            line_freq_select_o <= 1'b0;
            single_rate_o <= `SCG_S60_R0;
            cont_rate_o <= 19'd0;
            cont_avail_o <= 1'b0;
        end else begin
            rate_code_o <= rate_code;
            line_freq_select_o <= line_freq_select;
            single_rate_o <= rate_lookup(1'b0, line_freq_select,
                                         rate_code);
            cont_rate_o <= rate_lookup(1'b1, line_freq_select, rate_code);
            cont_avail_o <= rate_code[2];
        end
    end

    // checking helpers
    logic [GAIN_W-1:0] ast_prev_data;
    logic signed [GAIN_W+1:0] ast_diff;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ast_prev_data <= `SCG_GAIN_RST;
        end else begin
            ast_prev_data <= offs_data_i;
        end
    end
    assign ast_diff = $signed({result_o[GAIN_W-1], result_o[GAIN_W-1],
                               result_o})
                      - $signed({ast_prev_data[GAIN_W-1], ast_prev_data,
                                 1'b0});

    sequence s_gain_read_load;
        cmd_done && next_cmd[`SCG_CMD_RD_BIT]
        && sel_decode(next_cmd[1:0]) == SCG_SEL_GAIN;
    endsequence
    sequence s_gain_host_write;
        wr_fire && sel == SCG_SEL_GAIN && !cal_done_i;
    endsequence

    AST_RESET_CLEAR: assert property (@(posedge clk_i)
        !rstn_i |-> self_cal_gain_value == `SCG_GAIN_RST)
        else $error("gain not cleared in reset");
    AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_gain_read_load |=> sdo_o == $past(self_cal_gain_value[23]))
        else $error("gain read does not start at msb");
    AST_HOST_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_gain_host_write ##0 !cal_active_i
        |=> self_cal_gain_value == $past(next_rx))
        else $error("host gain write lost");
    AST_WRITE_BLOCKED: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        s_gain_host_write ##0 cal_active_i
        |=> $stable(self_cal_gain_value))
        else $error("gain written during calibration");
    AST_CAL_REPLACES: assert property (@(posedge clk_i)
        disable iff (!rstn_i)
        cal_done_i |=> self_cal_gain_value == $past(cal_gain_i))
        else $error("calibrated gain not taken");
    AST_HOLDS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !cal_done_i && !wr_fire |=> $stable(self_cal_gain_value))
        else $error("gain changed without cause");
    AST_BYPASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        offs_valid_i && self_gain_bypass
        |=> result_valid_o && result_o == $past(offs_data_i))
        else $error("bypass did not pass the sample");
    AST_UNITY: assert property (@(posedge clk_i) disable iff (!rstn_i)
        offs_valid_i && !self_gain_bypass
        && self_cal_gain_value == `SCG_UNITY_GAIN
        |=> result_o == $past(offs_data_i))
        else $error("unity gain altered the sample");
    AST_DOUBLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        offs_valid_i && !self_gain_bypass
        && self_cal_gain_value == `SCG_MAX_GAIN
        && offs_data_i[23] == offs_data_i[22]
        |=> ast_diff <= 26'sd2 && ast_diff >= -26'sd2)
        else $error("near-double gain off by more than two lsb");
    AST_RATE60: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !line_freq_select && rate_code == 3'h7
        |=> single_rate_o == `SCG_S60_R7
            && cont_rate_o == `SCG_C60_R7)
        else $error("60 Hz rate table wrong");
    AST_RATE50: assert property (@(posedge clk_i) disable iff (!rstn_i)
        line_freq_select && rate_code == 3'h0
        |=> single_rate_o == `SCG_S50_R0 && !cont_avail_o)
        else $error("50 Hz rate table wrong");
endmodule

// ===== verif/scg_host_model.sv
// serial host model driving the register port of the gain stage
`timescale 1ns/100ps
module scg_host_model (
    input wire logic clk_i, // core clock
    output logic sclk_o, // serial clock, idles low between frames
    output logic cs_n_o, // frame select, active low
    output logic sdi_o, // serial data to the device
    input wire logic sdo_i // serial data from the device
);
    // clocks per sclk phase, a margin above the two the filter needs
    localparam int HALF = 10;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // nbits below full cuts the data field short, which aborts the frame
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd,
                         input int nbits, input int full,
                         output logic [23:0] rd);
        logic [31:0] sh;
        rd = 24'h000000;
        sh = {cmd, wd << (24 - full)};
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        sdi_o <= sh[31];
        for (int i = 0; i < 8 + nbits; i++) begin
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b1;
            if (i >= 8)
                rd = {rd[22:0], sdo_i};
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b0;
            // a released line shows the inverse of its last bit
            sdi_o <= (i < 7 + nbits) ? sh[30 - i] : ~sh[31 - i];
        end
        repeat (HALF) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
    endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the gain stage, its registers and rate tables
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] %0t ns: got %0h exp %0h", $time, got, exp); end end
module tb_top;
    import scg_pkg::*;
    localparam int LIMIT = 60000;
    logic clk = 1'b0, rstn = 1'b0, sclk, cs_n, sdi, sdo, sdo_oen;
    logic cal_active = 1'b0, cal_done = 1'b0, offs_valid = 1'b0;
    logic [23:0] cal_gain = 24'h000000, offs_data = 24'h000000;
    logic result_valid, req, lf;
    logic [23:0] result, rd;
    logic [2:0] rate_code;
    scg_rate_t single_rate, cont_rate;
    logic cont_avail;
    int miscompares = 0, checked = 0, cycles = 0, req_cnt = 0;
    int s60[8] = '{1000, 2500, 5000, 10000, 15000, 30000, 60000, 120000};
    int s50[8] = '{833, 2080, 4170, 8330, 12500, 25000, 50000, 100000};

    always #25 clk = ~clk;

    scg_top u_dut (.clk_i(clk), .rstn_i(rstn), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oen_o(sdo_oen),
        .cal_active_i(cal_active), .cal_done_i(cal_done),
        .cal_gain_i(cal_gain), .offs_valid_i(offs_valid),
        .offs_data_i(offs_data), .result_valid_o(result_valid),
        .result_o(result), .self_cal_req_o(req),
        .rate_code_o(rate_code), .line_freq_select_o(lf),
        .single_rate_o(single_rate), .cont_rate_o(cont_rate),
        .cont_avail_o(cont_avail));
    scg_host_model u_host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi), .sdo_i(sdo));

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (req === 1'b1)
            req_cnt <= req_cnt + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [23:0] wd,
                      input int full);
        u_host.frame(cmd, wd, full, full, rd);
    endtask

    task automatic rd_gain(input logic [23:0] exp);
        u_host.frame(8'h80, 24'h000000, 24, 24, rd);
        `CHK(rd, exp)
    endtask

    // rounding half up, then clamp to the signed 24-bit range
    function automatic logic [23:0] scale(logic [23:0] d, logic [23:0] g);
        longint p;
        p = longint'($signed(d)) * longint'($signed(g));
        p = (p + 64'sh200000) >>> 22;
        if (p > 64'sh7FFFFF)
            p = 64'sh7FFFFF;
        if (p < -64'sh800000)
            p = -64'sh800000;
        return p[23:0];
    endfunction

    task automatic sample(input logic [23:0] d, input logic [23:0] exp);
        @(posedge clk);
        offs_valid <= 1'b1;
        offs_data <= d;
        @(posedge clk);
        offs_valid <= 1'b0;
        #1;
        `CHK(result_valid, 1'b1)
        `CHK(result, exp)
        @(posedge clk);
        #1;
        `CHK(result_valid, 1'b0)
    endtask

    task automatic t_reset();
        `CHK(sdo_oen, 1'b1)
        `CHK(single_rate, 19'd1000)
        `CHK(cont_avail, 1'b0)
        rd_gain(24'h000000);
    endtask

    task automatic t_gain_rw();
        logic [23:0] v[2] = '{24'hA53C96, 24'h5AC369};
        foreach (v[i]) begin
            wr(8'h00, v[i], 24);
            rd_gain(v[i]);
        end
    endtask

    task automatic t_scale();
        logic [23:0] g[5] = '{24'h400000, 24'h7FFFFF, 24'hC00000,
                              24'h7FFFFF, 24'h200000};
        logic [23:0] d[5] = '{24'h123456, 24'h100000, 24'h000005,
                              24'h500000, 24'h000003};
        wr(8'h01, 24'h000000, 8);
        foreach (g[i]) begin
            wr(8'h00, g[i], 24);
            sample(d[i], scale(d[i], g[i]));
        end
        wr(8'h01, 24'h000001, 8);
        sample(24'h876543, 24'h876543);
        wr(8'h01, 24'h000000, 8);
        sample(24'h000004, scale(24'h000004, 24'h200000));
    endtask

    task automatic t_cal();
        int n;
        wr(8'h00, 24'h111111, 24);
        @(posedge clk);
        cal_active <= 1'b1;
        n = req_cnt;
        wr(8'h00, 24'h222222, 24);
        rd_gain(24'h111111);
        wr(8'h02, 24'h000015, 8);
        u_host.frame(8'h82, 24'h000000, 8, 8, rd);
        `CHK(rd, 24'h000025)
        `CHK(req_cnt, n)
        @(posedge clk);
        cal_active <= 1'b0;
        cal_done <= 1'b1;
        cal_gain <= 24'h3ABCDE;
        @(posedge clk);
        cal_done <= 1'b0;
        rd_gain(24'h3ABCDE);
        wr(8'h02, 24'h000010, 8);
        `CHK(req_cnt, n + 1)
        wr(8'h00, 24'h654321, 24);
        rd_gain(24'h654321);
    endtask

    task automatic t_abort();
        u_host.frame(8'h00, 24'h0FFFFF, 12, 24, rd);
        rd_gain(24'h654321);
        u_host.frame(8'h83, 24'h000000, 24, 24, rd);
        `CHK(rd, 24'h000000)
    endtask

    task automatic t_rates();
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 8; c++) begin
                wr(8'h02, 24'(f * 8 + c), 8);
                `CHK(rate_code, 3'(c))
                `CHK(lf, 1'(f))
                `CHK(single_rate, 19'(f ? s50[c] : s60[c]))
                `CHK(cont_avail, 1'(c >= 4))
                `CHK(cont_rate, 19'(c < 4 ? 0 : (60 - 10 * f) * 1000 << (c - 4)))
            end
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_gain_rw();
        t_scale();
        t_cal();
        t_abort();
        t_rates();
        tally_and_finish();
    end
endmodule
